// ===== rfm_map.svh
`ifndef RFM_MAP_SVH
`define RFM_MAP_SVH

// ****************************************************
// Fault register bit positions
// ****************************************************
`define RFM_REG_FAULT_BIT      4
`define RFM_THERMAL_BIT        5
`define RFM_BACKFEED_BIT       6
`define RFM_FAULT_REG_WIDTH    8
`define RFM_FAULT_RESET        8'h00

// ****************************************************
// Timing
// ****************************************************
`define RFM_CLK_PERIOD_PS      25000
`define RFM_DEGLITCH_MIN_PS    7500000
`define RFM_DEGLITCH_NOM_PS    10000000
`define RFM_DEGLITCH_MAX_PS    12500000
// Nominal filter length in cycles, derived from the rate
`define RFM_DEGLITCH_CYCLES    (`RFM_DEGLITCH_NOM_PS / `RFM_CLK_PERIOD_PS)

`endif

// ===== rfm_pkg.sv
package rfm_pkg;
  typedef enum logic [1:0] {
    RFM_OFF,
    RFM_RUN,
    RFM_THERMAL_OFF,
    RFM_RAMP
  } rfm_state_t;
endpackage

// ===== rfm_deglitch.sv
`timescale 1ns/1ps
`include "rfm_map.svh"

// Stable-level filter: output follows input after CYCLES equal samples
module rfm_deglitch
  import rfm_pkg::*;
#(
  parameter int CYCLES = `RFM_DEGLITCH_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Level in and filtered level out
  input  wire logic level_in,
  output logic      level_out
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          out_reg;
  logic          out_next;

  // Restart count whenever input agrees with output, so short glitches never pass
  always_comb begin
    count_next = count_reg;
    out_next   = out_reg;
    if (level_in == out_reg) begin
      count_next = '0;
    end else if (count_reg == CW'(CYCLES - 1)) begin
      count_next = '0;
      out_next   = level_in;
    end else begin
      count_next = count_reg + 1'b1;
    end
  end

  // Registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_reg <= '0;
      out_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      out_reg   <= out_next;
    end
  end

  assign level_out = out_reg;
endmodule // rfm_deglitch

// ===== rfm_monitor.sv
//
// Overview of operation
// - While on, leaving regulation sets fault bit 4; register read clears it.
// - Reverse current while on opens supply path; path recloses when it clears.
// - Reverse current while on latches backfeed bit 6; register read clears it.
// - Overtemperature disables output only if also out of regulation; ramped restart.
// - Thermal disable latches bit 5; register read clears it.
// - Thermal detector filtered about 10 us (7.5 to 12.5 us) before use.
//
`timescale 1ns/1ps
`include "rfm_map.svh"

module rfm_monitor
  import rfm_pkg::*;
#(
  parameter int DEGLITCH_CYCLES = `RFM_DEGLITCH_CYCLES
) (
  // Clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            srst,
  // Regulator enable from device control
  input  wire logic                            supply2_enable,
  // Analog detector levels, asynchronous
  input  wire logic                            out_of_reg_det,
  input  wire logic                            backfeed_det,
  input  wire logic                            overtemp_det,
  // Soft-start done from the analog ramp
  input  wire logic                            ramp_done,
  // Host read strobe of the fault register
  input  wire logic                            fault_reg_read,
  // Regulator controls
  output logic                                 supply2_path_closed,
  output logic                                 supply2_output_on,
  output logic                                 supply2_soft_start,
  // Fault register image
  output logic [`RFM_FAULT_REG_WIDTH-1:0]      tracker_transceiver_fault_reg
);

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync1_next;
  logic [2:0] sync2_next;
  logic       ramp_s1_reg;
  logic       ramp_s2_reg;
  logic       ramp_s1_next;
  logic       ramp_s2_next;
  logic       ot_filt;

  // Detectors cross from the analog domain through two flops each.
  // A detector pulse shorter than one clock may be missed; the analog
  // side is expected to hold its level for several cycles.
  always_comb begin
    sync1_next   = {overtemp_det, backfeed_det, out_of_reg_det};
    sync2_next   = sync1_reg;
    ramp_s1_next = ramp_done;
    ramp_s2_next = ramp_s1_reg;
  end

  // Synchroniser flops
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_reg   <= 3'h0;
      sync2_reg   <= 3'h0;
      ramp_s1_reg <= 1'b0;
      ramp_s2_reg <= 1'b0;
    end else begin
      sync1_reg   <= sync1_next;
      sync2_reg   <= sync2_next;
      ramp_s1_reg <= ramp_s1_next;
      ramp_s2_reg <= ramp_s2_next;
    end
  end

  // ****************************************************
  // Thermal deglitch
  // ****************************************************
  // Filter is the only path by which overtemperature acts
  // Symmetric filter: release is delayed as much as the trip
  // Length is counted in clocks; retune it if the clock changes
  rfm_deglitch #(
    .CYCLES    (DEGLITCH_CYCLES)
  ) u_ot_filter (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .level_in  (sync2_reg[2]),
    .level_out (ot_filt)
  );

  // ****************************************************
  // Output state machine
  // ****************************************************
  // OFF: regulator disabled, detectors ignored
  // RUN: output regulated; hot alone is tolerated
  // THERMAL_OFF: output held off until filtered overtemp clears
  // RAMP: slope-controlled start or restart, left on ramp_done
  rfm_state_t state_reg;
  rfm_state_t state_next;
  logic       oor_on;
  logic       bf_on;
  logic       ot_on;
  logic       thermal_trip;

  // Gate every detector with supply2_enable, not with the state
  // Enable comes from the same clock, so it is used unsynchronised
  always_comb begin
    oor_on       = sync2_reg[0] & supply2_enable;
    bf_on        = sync2_reg[1] & supply2_enable;
    ot_on        = ot_filt & supply2_enable;
    thermal_trip = 1'b0;
    state_next   = state_reg;
    case (state_reg)
      RFM_OFF: begin
        if (supply2_enable) begin
          state_next = RFM_RAMP;
        end
      end
      RFM_RUN: begin
        if (!supply2_enable) begin
          state_next = RFM_OFF;
        end else if (ot_on && oor_on) begin
          // Hot alone is tolerated; hot and sagging is shut down
          state_next   = RFM_THERMAL_OFF;
          thermal_trip = 1'b1;
        end
      end
      RFM_THERMAL_OFF: begin
        if (!supply2_enable) begin
          state_next = RFM_OFF;
        end else if (!ot_filt) begin
          state_next = RFM_RAMP;
        end
      end
      RFM_RAMP: begin
        if (!supply2_enable) begin
          state_next = RFM_OFF;
        end else if (ot_on && oor_on) begin
          // Restarting into a still-hot, sagging output shuts down again
          state_next   = RFM_THERMAL_OFF;
          thermal_trip = 1'b1;
        end else if (ramp_s2_reg) begin
          state_next = RFM_RUN;
        end
      end
      default: begin
        state_next = RFM_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= RFM_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************
  // Regulator controls and fault flags
  // ****************************************************
  logic                           path_closed_reg;
  logic                           output_on_reg;
  logic                           soft_start_reg;
  logic                           path_next;
  logic                           on_next;
  logic                           soft_next;
  logic [`RFM_FAULT_REG_WIDTH-1:0] fault_next;

  // Output controls registered so pins never glitch
  always_comb begin
    // Path tracks backfeed directly, so it recloses without software
    path_next = supply2_enable & ~bf_on;
    // Controls follow the next state, so pins and state move together
    on_next   = (state_next == RFM_RUN) || (state_next == RFM_RAMP);
    soft_next = (state_next == RFM_RAMP);
    // Bits other than the three flags keep their reset zero
    fault_next = tracker_transceiver_fault_reg;
    // Read clears first, so a same-cycle event still sets the flag
    if (fault_reg_read) begin
      fault_next[`RFM_REG_FAULT_BIT] = 1'b0;
      fault_next[`RFM_THERMAL_BIT]   = 1'b0;
      fault_next[`RFM_BACKFEED_BIT]  = 1'b0;
    end
    if (oor_on) begin
      fault_next[`RFM_REG_FAULT_BIT] = 1'b1;
    end
    if (bf_on) begin
      fault_next[`RFM_BACKFEED_BIT] = 1'b1;
    end
    if (thermal_trip) begin
      fault_next[`RFM_THERMAL_BIT] = 1'b1;
    end
  end

  // Flag and control registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      path_closed_reg               <= 1'b0;
      output_on_reg                 <= 1'b0;
      soft_start_reg                <= 1'b0;
      tracker_transceiver_fault_reg <= `RFM_FAULT_RESET;
    end else begin
      path_closed_reg               <= path_next;
      output_on_reg                 <= on_next;
      soft_start_reg                <= soft_next;
      tracker_transceiver_fault_reg <= fault_next;
    end
  end

  // ****************************************************
  // Output pins
  // ****************************************************
  // Pins come straight from the flops above, no gating after them
  assign supply2_path_closed = path_closed_reg;
  assign supply2_output_on   = output_on_reg;
  assign supply2_soft_start  = soft_start_reg;

endmodule // rfm_monitor

// ===== rfm_monitor_chk.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module rfm_monitor_chk #(
  parameter int DEGLITCH_CYCLES = 400
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // Inputs
  input wire logic       supply2_enable,
  input wire logic       out_of_reg_det,
  input wire logic       backfeed_det,
  input wire logic       overtemp_det,
  input wire logic       ramp_done,
  input wire logic       fault_reg_read,
  // Outputs
  input wire logic       supply2_path_closed,
  input wire logic       supply2_output_on,
  input wire logic       supply2_soft_start,
  input wire logic [7:0] tracker_transceiver_fault_reg
);
  // Short aliases
  wire       en = supply2_enable;
  wire       bf = backfeed_det;
  wire [7:0] fr = tracker_transceiver_fault_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_reg_fault_set: assert property ((en && out_of_reg_det)[*4] |=> fr[4])
    else $error("regulation flag missing");
  chk_backfeed_open: assert property ((en && bf)[*4] |=> !supply2_path_closed && fr[6])
    else $error("path not opened");
  chk_path_reclose: assert property ((en && !bf)[*5] ##0 supply2_output_on |=> supply2_path_closed)
    else $error("path not reclosed");
  chk_backfeed_cause: assert property ($rose(fr[6]) |-> $past(bf, 3))
    else $error("backfeed flag without cause");
  chk_read_clear: assert property (((!out_of_reg_det && !bf)[*4] ##0 fault_reg_read) |=> !fr[4] && !fr[6])
    else $error("flags not cleared");
  chk_thermal_latch: assert property ($rose(fr[5]) |-> !supply2_output_on && fr[4])
    else $error("thermal flag without shutdown");
  chk_soft_end: assert property ((supply2_soft_start && ramp_done && en)[*3] |=> !supply2_soft_start)
    else $error("ramp not ended");
  chk_off_quiet: assert property (!en[*2] |=> !supply2_output_on && !supply2_path_closed)
    else $error("output active while off");
  chk_trip_flagged: assert property ($fell(supply2_output_on) && $past(en) |-> fr[5])
    else $error("output dropped while enabled without thermal flag");
  chk_off_no_flag: assert property (!en |=> !$rose(fr[4]) && !$rose(fr[5]) && !$rose(fr[6]))
    else $error("flag set while regulator off");
endmodule // rfm_monitor_chk

bind rfm_monitor rfm_monitor_chk #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) chk_u (
  .ref_clk(ref_clk), .srst(srst), .supply2_enable(supply2_enable),
  .out_of_reg_det(out_of_reg_det), .backfeed_det(backfeed_det),
  .overtemp_det(overtemp_det), .ramp_done(ramp_done), .fault_reg_read(fault_reg_read),
  .supply2_path_closed(supply2_path_closed), .supply2_output_on(supply2_output_on),
  .supply2_soft_start(supply2_soft_start),
  .tracker_transceiver_fault_reg(tracker_transceiver_fault_reg));

// ===== rfm_host_model.sv
`timescale 1ns/1ps
// Host side: one-cycle read strobe, captures the register image it read
module rfm_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Request from the bench and register image from the block
  input  wire logic       req,
  input  wire logic [7:0] fault_reg,
  // Read strobe to the block and captured image
  output logic            fault_reg_read,
  output logic [7:0]      seen
);
  // Each strobe lasts one cycle; a held req repeats it every other cycle
  always_ff @(posedge ref_clk) begin
    fault_reg_read <= req && !fault_reg_read;
    if (fault_reg_read) begin
      seen <= fault_reg;
    end
  end
endmodule // rfm_host_model

// ===== tb_regulator_fault_monitor.sv
`timescale 1ns/1ps
module tb_regulator_fault_monitor;
  logic       ref_clk, srst, en, oor, bf, ot, rdone, req, rd, pc, on, ss;
  logic [7:0] fr, seen;
  int         miscompares, n_compared, cycles;
  wire  [7:0] outs = {5'h00, pc, on, ss};
  // Short filter keeps the run brief
  rfm_monitor #(.DEGLITCH_CYCLES(4)) dut_u (.ref_clk(ref_clk), .srst(srst),
    .supply2_enable(en), .out_of_reg_det(oor), .backfeed_det(bf), .overtemp_det(ot),
    .ramp_done(rdone), .fault_reg_read(rd), .supply2_path_closed(pc),
    .supply2_output_on(on), .supply2_soft_start(ss), .tracker_transceiver_fault_reg(fr));
  rfm_host_model host_u (.ref_clk(ref_clk), .req(req), .fault_reg(fr),
    .fault_reg_read(rd), .seen(seen));
  // ****
  // Helpers
  // ****
  task automatic at(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic ck(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic host_read;
    at(1); req <= 1'b1; at(1); req <= 1'b0; at(3);
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_off;
    at(1); oor <= 1'b1; bf <= 1'b1; ot <= 1'b1;
    at(12); #1 ck(fr, 8'h00);
    ck(outs, 8'h00);
    at(1); oor <= 1'b0; bf <= 1'b0; ot <= 1'b0;
    at(10); $display("end off");
  endtask
  task automatic t_start;
    at(1); en <= 1'b1;
    at(3); #1 ck(outs, 8'h07);
    at(1); rdone <= 1'b1;
    at(5); #1 ck(outs, 8'h06);
    $display("end start");
  endtask
  task automatic t_oor;
    at(1); oor <= 1'b1;
    at(4); #1 ck(fr, 8'h10);
    at(1); oor <= 1'b0;
    at(4); host_read;
    #1 ck(seen, 8'h10);
    ck(fr, 8'h00);
    $display("end regulation");
  endtask
  task automatic t_bf;
    at(1); bf <= 1'b1;
    at(4); #1 ck(outs, 8'h02);
    ck(fr, 8'h40);
    host_read;
    #1 ck(fr, 8'h40);
    at(1); bf <= 1'b0;
    at(4); #1 ck(outs, 8'h06);
    host_read;
    #1 ck(fr, 8'h00);
    $display("end backfeed");
  endtask
  task automatic t_ot;
    at(1); ot <= 1'b1;
    at(12); #1 ck(outs, 8'h06);
    at(1); ot <= 1'b0;
    at(10); oor <= 1'b1; ot <= 1'b1;
    at(2); ot <= 1'b0;
    at(10); #1 ck(outs, 8'h06);
    at(1); ot <= 1'b1; rdone <= 1'b0;
    at(12); #1 ck({7'h00, on}, 8'h00);
    ck(fr, 8'h30);
    at(1); ot <= 1'b0; oor <= 1'b0;
    at(12); #1 ck({6'h00, on, ss}, 8'h03);
    at(1); rdone <= 1'b1;
    at(5); #1 ck(outs, 8'h06);
    host_read;
    #1 ck(fr, 8'h00);
    $display("end thermal");
  endtask
  // Drop enable in run, detectors must be ignored, then re-enable
  task automatic t_disable;
    at(1);
    en <= 1'b0;
    oor <= 1'b1;
    bf <= 1'b1;
    at(4);
    #1 ck(outs, 8'h00);
    ck(fr, 8'h00);
    at(1);
    en <= 1'b1;
    at(3);
    #1 ck(outs, 8'h02);
    ck(fr, 8'h50);
    at(1);
    oor <= 1'b0;
    bf <= 1'b0;
    at(4);
    #1 ck(outs, 8'h06);
    host_read;
    #1 ck(seen, 8'h50);
    ck(fr, 8'h00);
    $display("end disable");
  endtask
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end
  // Main sequence
  initial begin
    {srst, en, oor, bf, ot, rdone, req} = 7'h40;
    miscompares = 0;
    n_compared = 0;
    cycles = 0;
    at(10); srst <= 1'b0;
    t_off(); t_start(); t_oor(); t_bf(); t_ot();
    t_disable();
    conclude();
  end
endmodule // tb_regulator_fault_monitor
